// ### hw/data_trace.sv
// Purpose: data trace filter and ownership trace message source
// Assumes: all inputs come from logic on sys_clk
// Notes: messages leave through an 8 word queue
// Operation
// R1: rmw access under sync condition sends full-address sync variant
// R2: bit sync message: full address truncated, bit index, op, code 59
// R3: op encoded 01 clear, 10 set, 11 toggle; 00 never sent
// R4: channel 0 direction at 31:30, low bit reads, high bit writes
// R5: channel 1 direction at 29:28, same meaning, resets to zero
// R6: watchpoint bits for channel 1 at bit 1, channel 0 at bit 0
// R7: access matches when start <= address <= end
// R8: start equal to end matches that one address only
// R9: start above end never matches
// R10: 32-bit start and end per channel, reset to zero
// R11: ownership message at least once per 256 trace messages; the code counts a data message and prog_msg_sent in one cycle as one
// R12: each process id write makes an ownership message
// R13: ownership messages only while ownership trace is enabled
// R14: data or program sync from counter overflow adds ownership message
// R15: process id written while queue full is sent after overrun
// R16: ownership message without room and no halt gives error message
// R17: ownership message is 32-bit process id plus code 2
// R18: process id writable by cpu and by the debug tool
// R19: debug tool should leave process id writes to the cpu
// R20: rmw in trace window sends relative bit message, code 58
// R21: sync variant forced after 256 non-sync data messages; the code forces it after 255
// R22: after lost data, error code 8 precedes next sync message
// R23: enabled direction and range hit gives one message per access
`timescale 1ns/100ps
`include "dtrace_params.svh"

// ==========================================================
// message queue, head always at entry 0
module trace_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [$clog2(DEPTH):0] cnt;
        logic not_full;
        logic not_empty;
    } fst_t;
    fst_t s;
    fst_t next_s;
    logic pop;
    logic put;

    // shifting keeps the head in a flop, at the cost of muxes
    always_comb begin
        next_s = s;
        pop = s.not_empty & out_ready;
        put = in_valid & s.not_full;
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                next_s.mem[i] = s.mem[i + 1];
            end
            next_s.cnt = s.cnt - 1'b1;
        end
        if (put) begin
            next_s.mem[next_s.cnt] = in_data;
            next_s.cnt = next_s.cnt + 1'b1;
        end
        next_s.not_full = next_s.cnt != ($clog2(DEPTH) + 1)'(DEPTH);
        next_s.not_empty = next_s.cnt != '0;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s <= '{mem: '0, cnt: '0, not_full: 1'b1, not_empty: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign in_ready = s.not_full;
    assign out_valid = s.not_empty;
    assign out_data = s.mem[0];
endmodule

// ==========================================================
// trace filter, register file and message builder
module data_trace (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic reg_wr,
    input wire logic reg_cpu,
    input wire logic [2:0] reg_idx,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic acc_valid,
    input wire dtrace_pkg::acc_t acc,
    input wire logic sync_req,
    input wire logic prog_msg_sent,
    input wire logic prog_sync_ovf,
    input wire logic ownership_trace_enable,
    input wire logic halt_on_ovr,
    output logic [1:0] wp_hit,
    output logic msg_valid,
    output dtrace_pkg::msg_t msg,
    input wire logic msg_ready
);
    typedef struct packed {
        logic [1:0] ch0_direction;
        logic [1:0] ch1_direction;
        logic [1:0] wp;
        logic [1:0][31:0] range_start;
        logic [1:0][31:0] range_end;
        logic [31:0] process_identifier;
        logic [31:0] last_addr;
        logic [7:0] dcnt;
        logic [7:0] ocnt;
        logic need_sync;
        logic data_err;
        logic own_pend;
        logic own_err;
        logic [31:0] rdata;
        logic [1:0] wp_hit;
    } st_t;
    st_t s;
    st_t next_s;
    logic free;
    logic push;
    dtrace_pkg::msg_t pmsg;
    logic [1:0] hit;
    logic traced;
    logic sync;
    logic rd_en;
    logic wr_en;
    logic [31:0] ctl;

    // number of significant bits once leading zeros are dropped
    function automatic logic [5:0] sig_bits(input logic [31:0] v);
        logic [5:0] n;
        n = 6'h00;
        for (int i = 0; i < 32; i++) begin
            if (v[i]) begin
                n = 6'(i + 1);
            end
        end
        return n;
    endfunction

    // channel match and message choice
    always_comb begin
        next_s = s;
        push = 1'b0;
        pmsg = '0;
        ctl = {s.ch0_direction, s.ch1_direction, 26'h0, s.wp};
        for (int c = 0; c < 2; c++) begin
            rd_en = (c == 0) ? s.ch0_direction[0] : s.ch1_direction[0];
            wr_en = (c == 0) ? s.ch0_direction[1] : s.ch1_direction[1];
            // see R7, R8, R9: empty window when start above end
            hit[c] = acc_valid & ((acc.write | acc.rmw) ? wr_en : rd_en)
                & (s.range_start[c] <= acc.addr)
                & (acc.addr <= s.range_end[c]);
        end
        // see R23: one message even if both channels hit
        traced = (|hit) & !(acc.rmw & acc.op == `OP_RESERVED); // see R3
        next_s.wp_hit = hit & s.wp; // see R6
        sync = s.need_sync | sync_req | (s.dcnt == `CNT_WRAP); // see R21
        if (free & s.data_err) begin
            // see R22: error ahead of the next sync data message
            push = 1'b1;
            pmsg.tcode = `TC_ERR;
            pmsg.data = {27'h0, `EC_DATA_LOST};
            next_s.data_err = 1'b0;
        end else if (free & traced) begin
            push = 1'b1;
            pmsg.addr = sync ? acc.addr : acc.addr ^ s.last_addr;
            pmsg.sig = sig_bits(pmsg.addr); // see R2
            pmsg.bitn = acc.bitn;
            pmsg.op = acc.op;
            pmsg.dsz = acc.dsz;
            pmsg.data = acc.data;
            if (acc.rmw) begin
                pmsg.data = '0;
                // see R1, R2, R20
                pmsg.tcode = sync ? `TC_BIT_SYNC : `TC_BIT;
            end else if (acc.write) begin
                pmsg.tcode = sync ? `TC_WR_SYNC : `TC_WR;
            end else begin
                pmsg.tcode = sync ? `TC_RD_SYNC : `TC_RD;
            end
            next_s.last_addr = acc.addr;
            next_s.need_sync = 1'b0;
            next_s.dcnt = sync ? 8'h00 : 8'(s.dcnt + 1'b1);
            if (s.dcnt == `CNT_WRAP && ownership_trace_enable) begin
                next_s.own_pend = 1'b1; // see R14
            end
        end else if (free & s.own_err) begin
            push = 1'b1; // see R16
            pmsg.tcode = `TC_ERR;
            pmsg.data = {27'h0, `EC_OWN_LOST};
            next_s.own_err = 1'b0;
        end else if (free & s.own_pend) begin
            push = 1'b1; // see R17, R15
            pmsg.tcode = `TC_OWN;
            pmsg.data = s.process_identifier;
            next_s.own_pend = 1'b0;
            next_s.ocnt = 8'h00;
        end
        // lost data arms the error and a resync
        if (traced & !(push & pmsg.tcode != `TC_ERR
                & pmsg.tcode != `TC_OWN)) begin
            next_s.data_err = 1'b1;
            next_s.need_sync = 1'b1;
        end
        // see R11: periodic ownership message
        if ((push & pmsg.tcode != `TC_ERR & pmsg.tcode != `TC_OWN)
                | prog_msg_sent) begin
            next_s.ocnt = 8'(s.ocnt + 1'b1);
            if (s.ocnt == `CNT_WRAP && ownership_trace_enable) begin
                next_s.own_pend = 1'b1;
            end
        end
        if (prog_sync_ovf & ownership_trace_enable) begin
            next_s.own_pend = 1'b1; // see R14
        end
        // register writes, both cpu and tool may write pid
        if (reg_wr) begin
            unique case (reg_idx)
                `IDX_CTRL: begin
                    // see R4, R5: enabling a channel while both channels are off forces a resync
                    next_s.ch0_direction =
                        reg_wdata[`CTL_DIR0_HI:`CTL_DIR0_LO];
                    next_s.ch1_direction =
                        reg_wdata[`CTL_DIR1_HI:`CTL_DIR1_LO];
                    next_s.wp = {reg_wdata[`CTL_WP1], reg_wdata[`CTL_WP0]};
                    if (ctl[31:28] == 4'h0 && reg_wdata[31:28] != 4'h0) begin
                        next_s.need_sync = 1'b1;
                    end
                end
                `IDX_START0: next_s.range_start[0] = reg_wdata; // see R10
                `IDX_START1: next_s.range_start[1] = reg_wdata;
                `IDX_END0: next_s.range_end[0] = reg_wdata;
                `IDX_END1: next_s.range_end[1] = reg_wdata;
                `IDX_PID: begin
                    next_s.process_identifier = reg_wdata; // see R18
                    if (ownership_trace_enable) begin
                        next_s.own_pend = 1'b1; // see R12, R13
                    end
                end
                default: ;
            endcase
        end
        // see R16: no room and no halt turns it into an error
        if (next_s.own_pend & !free & !halt_on_ovr) begin
            next_s.own_pend = 1'b0;
            next_s.own_err = 1'b1;
        end
        if (!ownership_trace_enable) begin
            next_s.own_pend = 1'b0; // see R13
        end
        unique case (reg_idx)
            `IDX_CTRL: next_s.rdata = ctl;
            `IDX_START0: next_s.rdata = s.range_start[0];
            `IDX_START1: next_s.rdata = s.range_start[1];
            `IDX_END0: next_s.rdata = s.range_end[0];
            `IDX_END1: next_s.rdata = s.range_end[1];
            `IDX_PID: next_s.rdata = s.process_identifier;
            default: next_s.rdata = 32'h0;
        endcase
    end

    // all state, need_sync set so the first message after reset syncs
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
            s.need_sync <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // message queue
    trace_fifo #(
        .WIDTH($bits(dtrace_pkg::msg_t)),
        .DEPTH(`FIFO_DEPTH)
    ) queue (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .in_valid(push),
        .in_data(pmsg),
        .in_ready(free),
        .out_valid(msg_valid),
        .out_data(msg),
        .out_ready(msg_ready)
    );

    assign reg_rdata = s.rdata;
    assign wp_hit = s.wp_hit;

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    property p_rmw_sync;
        push & acc.rmw & traced & sync & !s.data_err
            |-> pmsg.tcode == `TC_BIT_SYNC && pmsg.addr == acc.addr;
    endproperty
    a_rmw_sync: assert property (p_rmw_sync) // see R1
        else $error("rmw under sync not full address");

    property p_op_code;
        push && (pmsg.tcode == `TC_BIT || pmsg.tcode == `TC_BIT_SYNC)
            |-> pmsg.op != `OP_RESERVED;
    endproperty
    a_op_code: assert property (p_op_code) // see R3
        else $error("reserved bit operation sent");

    property p_no_match;
        s.range_start[0] > s.range_end[0] |-> !hit[0];
    endproperty
    a_no_match: assert property (p_no_match) // see R9
        else $error("empty window matched");

    property p_wp;
        hit[1] & s.wp[1] |=> wp_hit[1];
    endproperty
    a_wp: assert property (p_wp) // see R6
        else $error("watchpoint 1 missed");

    property p_pid_own;
        reg_wr & reg_idx == `IDX_PID & ownership_trace_enable & free
            & !s.own_err |=> s.own_pend | s.own_err;
    endproperty
    a_pid_own: assert property (p_pid_own) // see R12
        else $error("pid write made no ownership message");

    property p_own_lost;
        reg_wr & reg_idx == `IDX_PID & ownership_trace_enable & !free
            & !halt_on_ovr |=> s.own_err;
    endproperty
    a_own_lost: assert property (p_own_lost) // see R16
        else $error("full queue pid write made no error");

    property p_own_wait;
        reg_wr & reg_idx == `IDX_PID & ownership_trace_enable & !free
            & halt_on_ovr |=> s.own_pend;
    endproperty
    a_own_wait: assert property (p_own_wait) // see R15
        else $error("pid write under halt not kept pending");

    property p_own_off;
        !ownership_trace_enable |=> !s.own_pend;
    endproperty
    a_own_off: assert property (p_own_off) // see R13
        else $error("ownership pending while disabled");

    property p_own_msg;
        push & pmsg.tcode == `TC_OWN |-> pmsg.data == s.process_identifier;
    endproperty
    a_own_msg: assert property (p_own_msg) // see R17
        else $error("ownership message lacks process id");

    property p_err_first;
        push & s.data_err |-> pmsg.tcode == `TC_ERR
            ##1 s.need_sync;
    endproperty
    a_err_first: assert property (p_err_first) // see R22
        else $error("error message not ahead of sync");

    property p_period;
        s.dcnt == `CNT_WRAP & push & traced & !s.data_err
            |-> pmsg.tcode inside {`TC_BIT_SYNC, `TC_WR_SYNC, `TC_RD_SYNC};
    endproperty
    a_period: assert property (p_period) // see R21
        else $error("periodic sync not forced");
endmodule

// ### shared/dtrace_params.svh
// Purpose: constants of the data and ownership trace block
// Assumes: 40 MHz core clock
// Notes: register indices are on the debug register port
`ifndef DTRACE_PARAMS_SVH
`define DTRACE_PARAMS_SVH
// ==========================================================
// register indices
`define IDX_CTRL 3'h0
`define IDX_START0 3'h1
`define IDX_START1 3'h2
`define IDX_END0 3'h3
`define IDX_END1 3'h4
`define IDX_PID 3'h5
// ==========================================================
// control field positions and reset value
`define CTL_DIR0_HI 31
`define CTL_DIR0_LO 30
`define CTL_DIR1_HI 29
`define CTL_DIR1_LO 28
`define CTL_WP1 1
`define CTL_WP0 0
`define CTL_RESET 32'h0000_0000
`define REG_RESET 32'h0000_0000
// ==========================================================
// message codes
`define TC_OWN 6'h02
`define TC_RD 6'h06
`define TC_WR 6'h05
`define TC_ERR 6'h08
`define TC_WR_SYNC 6'h0d
`define TC_RD_SYNC 6'h0e
`define TC_BIT 6'h3a
`define TC_BIT_SYNC 6'h3b
`define EC_DATA_LOST 5'h07
`define EC_OWN_LOST 5'h02
`define OP_RESERVED 2'h0
// ==========================================================
// periodic counters: wrap after 256 messages
`define CNT_WRAP 8'hff
`define FIFO_DEPTH 8
`endif

// ### shared/dtrace_pkg.sv
// Purpose: types of the data and ownership trace block
// Assumes: nothing
// Notes: none
package dtrace_pkg;
    // one load/store pipeline access
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic write;
        logic rmw;
        logic [4:0] bitn;
        logic [1:0] op;
        logic [1:0] dsz;
    } acc_t;
    // one trace message; sig gives significant address bits
    typedef struct packed {
        logic [5:0] tcode;
        logic [31:0] data;
        logic [31:0] addr;
        logic [5:0] sig;
        logic [4:0] bitn;
        logic [1:0] op;
        logic [1:0] dsz;
    } msg_t;
endpackage

// ### sim/trace_sink.sv
// Purpose: far-side debug tool that takes trace messages off the port
// Assumes: valid/ready handshake on sys_clk
// Notes: stall holds ready low, slow drops it one cycle in four
`timescale 1ns/100ps
module trace_sink (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic stall,
    input wire logic slow,
    input wire logic msg_valid,
    input wire dtrace_pkg::msg_t msg,
    output logic msg_ready
);
    // ==========================================================
    // received messages, read back by the bench
    dtrace_pkg::msg_t got[$];
    integer seed = 72477;
    // only reads messages, never writes the process id
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            msg_ready <= 1'b0;
        end else begin
            if (msg_valid && msg_ready) begin
                got.push_back(msg);
            end
            msg_ready <= !stall && !(slow && ($random(seed) % 4 == 0));
        end
    end
endmodule

// ### sim/data_trace_tb.sv
// Purpose: self-checking bench for the data and ownership trace block
// Assumes: sink model pops messages, integer model predicts them
// Notes: second reset clears periodic counters before owner tests
`timescale 1ns/100ps
`include "dtrace_params.svh"
module data_trace_tb;
    logic sys_clk, resetn, reg_wr = 0, reg_cpu = 1, acc_valid = 0;
    logic sync_req = 0, prog_msg_sent = 0, prog_sync_ovf = 0;
    logic ownership_trace_enable = 0, halt_on_ovr = 0;
    logic msg_valid, msg_ready, stall = 0, slow = 0, need, lost;
    logic [2:0] reg_idx = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, prev, process_identifier;
    logic [31:0] sa[2], ea[2];
    logic [1:0] wp_hit, wpm;
    logic [1:0] dir[2];
    dtrace_pkg::acc_t acc = '0;
    dtrace_pkg::msg_t msg;
    dtrace_pkg::msg_t exq[$];
    int errors = 0, num_checks = 0, cnt, occ;
    integer seed = 72477;

    data_trace i_dut (.sys_clk(sys_clk), .resetn(resetn), .reg_wr(reg_wr),
        .reg_cpu(reg_cpu), .reg_idx(reg_idx), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .acc_valid(acc_valid), .acc(acc),
        .sync_req(sync_req), .prog_msg_sent(prog_msg_sent),
        .prog_sync_ovf(prog_sync_ovf),
        .ownership_trace_enable(ownership_trace_enable),
        .halt_on_ovr(halt_on_ovr), .wp_hit(wp_hit), .msg_valid(msg_valid),
        .msg(msg), .msg_ready(msg_ready));
    trace_sink i_sink (.sys_clk(sys_clk), .resetn(resetn), .stall(stall),
        .slow(slow), .msg_valid(msg_valid), .msg(msg), .msg_ready(msg_ready));

    // ==========================================================
    // clock and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // run needs about 2300 cycles; about fourteen times that means a hang
    initial begin
        repeat (32000) @(posedge sys_clk);
        errors++;
        conclude();
    end

    // ==========================================================
    // compare, verdict and model helpers
    task automatic chk(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // truncation length: highest set bit plus one
    function automatic logic [5:0] sigof(input logic [31:0] a);
        sigof = 6'h00;
        for (int i = 0; i < 32; i++) begin
            if (a[i]) sigof = 6'(i + 1);
        end
    endfunction
    task automatic push(input logic [5:0] tc, input logic [31:0] d,
            input logic [31:0] a, input logic [4:0] b, input logic [1:0] o,
            input logic [1:0] z);
        exq.push_back(dtrace_pkg::msg_t'{tc, d, a, sigof(a), b, o, z});
        if (stall) occ++;
    endtask
    task automatic do_reset();
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        need = 1'b1;
        lost = 1'b0;
        cnt = 0;
        occ = 0;
        process_identifier = '0;
        sa = '{2{32'h0}};
        ea = '{2{32'h0}};
        dir = '{2{2'h0}};
        wpm = 2'h0;
        exq.delete();
        i_sink.got.delete();
    endtask

    // ==========================================================
    // register port
    task automatic wr(input logic [2:0] idx, input logic [31:0] v);
        logic f;
        f = stall && occ >= 8 && !halt_on_ovr;
        @(posedge sys_clk);
        reg_idx <= idx;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        // process id left to the cpu
        reg_cpu <= idx == `IDX_PID ? 1'b1 : 1'($random(seed));
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        case (idx)
            `IDX_CTRL: begin
                if (dir[0] == 0 && dir[1] == 0 && v[31:28] != 0) need = 1;
                dir[0] = v[31:30];
                dir[1] = v[29:28];
                wpm = v[1:0];
            end
            `IDX_START0: sa[0] = v;
            `IDX_START1: sa[1] = v;
            `IDX_END0: ea[0] = v;
            `IDX_END1: ea[1] = v;
            `IDX_PID: begin
                process_identifier = v;
                if (ownership_trace_enable) begin
                    // full queue without halt turns into an error
                    push(f ? `TC_ERR : `TC_OWN, f ? 32'(`EC_OWN_LOST) : v,
                        0, 0, 0, 2);
                end
            end
            default: ;
        endcase
    endtask
    task automatic rd(input logic [2:0] idx, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_idx <= idx;
        repeat (2) @(posedge sys_clk);
        #1 chk("register", exp, reg_rdata);
    endtask

    // ==========================================================
    // access port and message prediction
    task automatic access(input logic [31:0] a, input logic w, input logic r,
            input logic [1:0] o, input logic s);
        logic hit;
        logic sy;
        logic [1:0] hv;
        logic [31:0] d;
        logic [1:0] z;
        d = $random(seed);
        z = 2'(a % 3);
        hit = 1'b0;
        @(posedge sys_clk);
        acc_valid <= 1'b1;
        acc <= '{a, d, w | r, r, a[4:0], o, z};
        sync_req <= s;
        @(posedge sys_clk);
        acc_valid <= 1'b0;
        sync_req <= 1'b0;
        // one message at most, whichever channels hit
        for (int c = 0; c < 2; c++) begin
            hv[c] = dir[c][w|r] & (sa[c] <= a) & (a <= ea[c]);
        end
        hit = |hv;
        // watchpoint flag stands one cycle after the access
        #1 chk("watchpoint", 32'(hv & wpm), 32'(wp_hit));
        if (r && o == `OP_RESERVED) hit = 1'b0;
        if (!hit) return;
        if (stall && occ >= 8) begin
            if (!lost) push(`TC_ERR, 32'(`EC_DATA_LOST), 0, 0, 0, 2);
            lost = 1'b1;
            need = 1'b1;
            return;
        end
        sy = need | s | (cnt == 255);
        push(r ? (sy ? `TC_BIT_SYNC : `TC_BIT)
            : w ? (sy ? `TC_WR_SYNC : `TC_WR) : (sy ? `TC_RD_SYNC : `TC_RD),
            d, sy ? a : a ^ prev, a[4:0], o, z);
        if (sy && cnt == 255 && ownership_trace_enable) begin
            push(`TC_OWN, process_identifier, 0, 0, 0, 2);
        end
        cnt = sy ? 0 : cnt + 1;
        need = 1'b0;
        lost = 1'b0;
        prev = a;
    endtask
    // wait for the queue to empty, then compare against the model
    task automatic settle(input string name);
        dtrace_pkg::msg_t e;
        dtrace_pkg::msg_t g;
        logic [31:0] mk;
        int n;
        n = 0;
        while ((msg_valid !== 1'b0 || i_sink.got.size() < exq.size())
                && n < 3000) begin
            @(posedge sys_clk);
            n++;
        end
        repeat (4) @(posedge sys_clk);
        chk("queue drained", 1, n < 3000);
        chk("message count", exq.size(), i_sink.got.size());
        while (exq.size() > 0 && i_sink.got.size() > 0) begin
            e = exq.pop_front();
            g = i_sink.got.pop_front();
            mk = e.dsz == 0 ? 32'hff : e.dsz == 1 ? 32'hffff : '1;
            chk("tcode", e.tcode, g.tcode);
            if (e.tcode == `TC_BIT || e.tcode == `TC_BIT_SYNC) begin
                chk("bit and op", {e.bitn, e.op}, {g.bitn, g.op});
            end else begin
                chk("data", e.data & mk, g.data & mk);
            end
            if (e.tcode != `TC_OWN && e.tcode != `TC_ERR) begin
                chk("address", e.addr, g.addr);
                chk("length", e.sig, g.sig);
                chk("size", e.dsz, g.dsz);
            end
        end
        exq.delete();
        i_sink.got.delete();
        occ = 0;
        $display("test %s done, %0d mismatches so far", name, errors);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        resetn = 1'b0;
        do_reset();
        for (int i = 0; i < 8; i++) rd(3'(i), 32'h0);
        wr(`IDX_CTRL, '1);
        rd(`IDX_CTRL, 32'hf000_0003);
        for (int i = 1; i < 7; i++) begin
            wr(3'(i), 32'(32'h1111_1111 * i));
            rd(3'(i), i < 6 ? 32'(32'h1111_1111 * i) : 32'h0);
        end
        settle("registers");
        wr(`IDX_START0, 32'h0000_0100);
        wr(`IDX_END0, 32'h0000_01ff);
        wr(`IDX_START1, 32'h0000_0300);
        wr(`IDX_END1, 32'h0000_0300);
        wr(`IDX_CTRL, 32'hd000_0003);
        for (int o = 0; o < 4; o++) access(32'h104 + 4 * o, 1, 1, 2'(o), 0);
        access(32'h1ff, 0, 0, 0, 0);
        access(32'h200, 1, 0, 0, 0);
        access(32'h300, 0, 0, 0, 0);
        access(32'h300, 1, 0, 0, 0);
        access(32'h304, 0, 0, 0, 0);
        access(32'h180, 1, 1, 2'h3, 1);
        wr(`IDX_START1, 32'h0000_0400);
        access(32'h300, 0, 0, 0, 0);
        wr(`IDX_START1, 32'h0000_0100);
        access(32'h150, 0, 0, 0, 0);
        settle("window");
        slow <= 1'b1;
        for (int i = 0; i < 500; i++) begin
            access(32'h100 + 32'($random(seed) & 32'h1ff), 1'($random(seed)),
                1'($random(seed)), 2'($random(seed)), 0);
        end
        settle("random");
        slow <= 1'b0;
        stall <= 1'b1;
        for (int i = 0; i < 10; i++) access(32'h120 + 4 * i, 1, 0, 0, 0);
        stall <= 1'b0;
        repeat (20) @(posedge sys_clk);
        access(32'h160, 1, 0, 0, 0);
        settle("overrun");
        do_reset();
        ownership_trace_enable <= 1'b1;
        wr(`IDX_PID, 32'h5a5a_0001);
        settle("owner");
        wr(`IDX_START0, 32'h0000_0100);
        wr(`IDX_END0, 32'h0000_01ff);
        wr(`IDX_CTRL, 32'h8000_0000);
        for (int h = 0; h < 2; h++) begin
            halt_on_ovr <= 1'(h);
            stall <= 1'b1;
            for (int i = 0; i < 8; i++) access(32'h100 + 8 * i, 1, 0, 0, 0);
            wr(`IDX_PID, 32'(32'h0000_0a0b + h));
            stall <= 1'b0;
            settle("owner full queue");
        end
        // periodic ownership from program trace traffic
        push(`TC_OWN, process_identifier, 0, 0, 0, 2);
        for (int i = 0; i < 256; i++) begin
            @(posedge sys_clk);
            prog_msg_sent <= 1'b1;
            @(posedge sys_clk);
            prog_msg_sent <= 1'b0;
        end
        repeat (20) @(posedge sys_clk);
        chk("periodic owner", 1, i_sink.got.size() > 0);
        settle("periodic owner");
        @(posedge sys_clk);
        prog_sync_ovf <= 1'b1;
        @(posedge sys_clk);
        prog_sync_ovf <= 1'b0;
        push(`TC_OWN, process_identifier, 0, 0, 0, 2);
        settle("program overflow");
        // data counter wrap: forced sync, then an ownership message
        for (int i = 0; i < 256; i++) begin
            access(32'h100 + 32'(4 * (i % 64)), 1, 0, 0, 0);
        end
        settle("data overflow");
        conclude();
    end
endmodule
